// [core/sacc_conversion_control.sv]
/*
 Digital control of an 8-bit successive-approximation converter.
 Assumes a synchronous comparator input and a 10 MHz clock; the result pin
 level is resolved outside from o_data and o_data_oe.
*/
// Behaviour
// - Trial bits tested one at a time, MSB first, LSB last.
// - Keep bit when comparator says sum below input, else clear it.
// - After all bits decided, register holds the 8-bit result.
// - At completion, done flag falls low and result lines get driven.
// - Rising convert line releases result drivers and re-arms register.
// - Bipolar select grounded gives unipolar straight binary coding.
// - Bipolar select open gives offset binary, zero input 10000000.
// - Standby with convert line high: lines released, done flag high.
// - Falling convert line starts conversion; data driven within 500 ns of done.
// - About 1.5 us after line rises, done rises and data lines release.
// - Rise mid-conversion halts it; 2 us high pulse clears and restarts.
`include "sacc_defines.svh"
module sacc_conversion_control (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_blank_convert_n,
   input wire logic i_sum_below,
   input wire logic i_bipolar_open,
   output logic o_conversion_done_n,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic o_bipolar_offset_on,
   output logic [7:0] o_dac_code
);
   import sacc_pkg::*;

   sacc_state_type state, next_state;
   sacc_code_type approximation_register, next_approximation_register;
   sacc_code_type trial, next_trial;
   logic [4:0] timer, next_timer;
   logic [4:0] high_count, next_high_count;
   logic conversion_done_n, next_conversion_done_n;
   logic data_oe, next_data_oe;
   logic bipolar_offset_on, next_bipolar_offset_on;
   sacc_code_type step_code, step_trial;
   logic drive_due, release_due;

   // Saturating count of cycles since the line rose; stops once the clear length is reached
   function automatic logic [4:0] count_high(input logic [4:0] count);
      logic [4:0] result;
      result = count;
      if (count < 5'(`SACC_CLEAR_PULSE_CYC)) begin
         result = count + 5'h1;
      end
      return result;
   endfunction

   // Line high long enough to clear the converter
   function automatic logic pulse_cleared(input logic [4:0] count);
      return count >= 5'(`SACC_CLEAR_PULSE_CYC);
   endfunction

   // Wait counter on the last cycle of its span
   function automatic logic span_over(input logic [4:0] count, input logic [4:0] last);
      return count >= last;
   endfunction

   // Both delays share one timer: drive and release never overlap
   assign drive_due = span_over(timer, 5'(`SACC_DRIVE_DELAY_CYC - 1));
   assign release_due = span_over(timer, 5'(`SACC_RELEASE_DELAY_CYC - 1));

   sacc_trial_step u_step (
      .i_code(approximation_register),
      .i_trial(trial),
      .i_sum_below(i_sum_below),
      .o_code(step_code),
      .o_trial(step_trial)
   );

   always_comb begin
      next_state = state;
      next_approximation_register = approximation_register;
      next_trial = trial;
      next_timer = timer;
      next_high_count = high_count;
      next_conversion_done_n = conversion_done_n;
      next_data_oe = data_oe;
      // Offset current only switched between conversions so codes stay coherent
      next_bipolar_offset_on = bipolar_offset_on;
      case (state)
         SACC_STANDBY: begin
            next_conversion_done_n = 1'b1;
            next_data_oe = 1'b0;
            next_bipolar_offset_on = i_bipolar_open;
            if (!i_blank_convert_n) begin
               next_state = SACC_CONVERT;
               next_approximation_register = `SACC_MSB_MASK;
               next_trial = `SACC_MSB_MASK;
            end
         end
         SACC_CONVERT: begin
            if (i_blank_convert_n) begin
               next_state = SACC_HALTED;
               next_high_count = 5'd1;
            end else begin
               next_approximation_register = step_code;
               next_trial = step_trial;
               if (trial[0]) begin
                  next_state = SACC_DONE;
                  next_conversion_done_n = 1'b0;
                  next_timer = 5'd0;
               end
            end
         end
         SACC_HALTED: begin
            // Done flag and data lines left as they were
            if (!i_blank_convert_n) begin
               if (pulse_cleared(high_count)) begin
                  next_state = SACC_CONVERT;
                  next_approximation_register = `SACC_MSB_MASK;
                  next_trial = `SACC_MSB_MASK;
               end else begin
                  // Short glitch: resume where stopped
                  next_state = SACC_CONVERT;
               end
            end else begin
               next_high_count = count_high(high_count);
            end
         end
         SACC_DONE: begin
            if (!drive_due) begin
               next_timer = timer + 5'h1;
            end else begin
               next_data_oe = 1'b1;
            end
            if (i_blank_convert_n) begin
               next_state = SACC_RELEASE;
               next_timer = 5'h0;
               next_high_count = 5'h1;
            end
         end
         SACC_RELEASE: begin
            next_high_count = count_high(high_count);
            if (!release_due) begin
               next_timer = timer + 5'h1;
            end else begin
               next_conversion_done_n = 1'b1;
               next_data_oe = 1'b0;
               next_approximation_register = `SACC_CODE_ZERO;
               // Full span always kept, even if drivers never came on
               // Early low waits for the clear length, then starts afresh
               if (i_blank_convert_n || pulse_cleared(high_count)) begin
                  next_state = SACC_STANDBY;
               end
            end
         end
         default: begin
            next_state = SACC_STANDBY;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state <= SACC_STANDBY;
         approximation_register <= `SACC_CODE_ZERO;
         trial <= `SACC_CODE_ZERO;
         timer <= 5'd0;
         high_count <= 5'd0;
         conversion_done_n <= 1'b1;
         data_oe <= 1'b0;
         bipolar_offset_on <= 1'b0;
      end else begin
         state <= next_state;
         approximation_register <= next_approximation_register;
         trial <= next_trial;
         timer <= next_timer;
         high_count <= next_high_count;
         conversion_done_n <= next_conversion_done_n;
         data_oe <= next_data_oe;
         bipolar_offset_on <= next_bipolar_offset_on;
      end
   end

   // Output registers mirror state so every output is a flop
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_conversion_done_n <= 1'b1;
         o_data <= `SACC_CODE_ZERO;
         o_data_oe <= 1'b0;
         o_bipolar_offset_on <= 1'b0;
         o_dac_code <= `SACC_CODE_ZERO;
      end else begin
         o_conversion_done_n <= next_conversion_done_n;
         o_data <= next_approximation_register;
         o_data_oe <= next_data_oe;
         o_bipolar_offset_on <= next_bipolar_offset_on;
         o_dac_code <= next_approximation_register;
      end
   end
endmodule // sacc_conversion_control

// [core/sacc_defines.svh]
/*
 Timing counts and code constants for the APPROXIMATION_REGISTER conversion control.
 Assumes a 10 MHz clock (100 ns period).
*/
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH
`define SACC_CLK_PERIOD_NS 100
`define SACC_RESULT_WIDTH 8
`define SACC_DRIVE_DELAY_NS 500
`define SACC_DRIVE_DELAY_CYC ((`SACC_DRIVE_DELAY_NS) / (`SACC_CLK_PERIOD_NS))
`define SACC_RELEASE_DELAY_NS 1500
`define SACC_RELEASE_DELAY_CYC ((`SACC_RELEASE_DELAY_NS) / (`SACC_CLK_PERIOD_NS))
`define SACC_CLEAR_PULSE_NS 2000
`define SACC_CLEAR_PULSE_CYC \
   (((`SACC_CLEAR_PULSE_NS) + (`SACC_CLK_PERIOD_NS) - 1) / (`SACC_CLK_PERIOD_NS))
`define SACC_MSB_MASK 8'h80
`define SACC_CODE_ZERO 8'h00
`endif

// [core/sacc_pkg.sv]
/*
 Types for the APPROXIMATION_REGISTER conversion control.
 Assumes nothing beyond the defines header.
*/
package sacc_pkg;
   typedef logic [7:0] sacc_code_type;
   typedef enum logic [2:0] {
      SACC_STANDBY = 3'b000,
      SACC_CONVERT = 3'b001,
      SACC_HALTED = 3'b010,
      SACC_DONE = 3'b011,
      SACC_RELEASE = 3'b100
   } sacc_state_type;
endpackage

// [core/sacc_trial_step.sv]
/*
 One successive-approximation step: decides the current trial bit and
 places the next one. Assumes the comparator answer is valid for the trial.
*/
module sacc_trial_step (
   input wire logic [7:0] i_code,
   input wire logic [7:0] i_trial,
   input wire logic i_sum_below,
   output logic [7:0] o_code,
   output logic [7:0] o_trial
);
   always_comb begin
      // Keep bit when sum below input, else drop it; next bit set for trial
      o_code = i_sum_below ? i_code : (i_code & ~i_trial);
      o_trial = {1'b0, i_trial[7:1]};
      o_code = o_code | o_trial;
   end
endmodule // sacc_trial_step

// [tb/sacc_comparator_model.sv]
/* Behavioural comparator and input level for the conversion control.
   Assumes the trial code drives an ideal DAC with no settling time. */
module sacc_comparator_model (
   input wire logic [7:0] i_dac_code,
   input wire logic [7:0] i_level,
   output logic o_sum_below
);
   timeunit 1ns;
   timeprecision 1ns;
   // Equal counts as below so the result lands on the level itself
   assign o_sum_below = (i_dac_code <= i_level);
endmodule // sacc_comparator_model

// [tb/sacc_conversion_control_props.sv]
/* Checker for the conversion control ports, bound into the design.
   Assumes one clock domain and the synchronous active low reset. */
module sacc_conversion_control_props (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_blank_convert_n,
   input wire logic o_conversion_done_n,
   input wire logic [7:0] o_data,
   input wire logic o_data_oe,
   input wire logic o_bipolar_offset_on,
   input wire logic [7:0] o_dac_code
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   start_msb_a: assert property ($fell(i_blank_convert_n) && o_conversion_done_n &&
      o_dac_code == 8'h00 |-> ##[1:2] o_dac_code == 8'h80) else $error("no msb trial");
   done_drive_a: assert property ($fell(o_conversion_done_n) |->
      !o_data_oe [*5] ##1 o_data_oe) else $error("drive delay wrong");
   idle_release_a: assert property (o_conversion_done_n |-> !o_data_oe)
      else $error("driven while not done");
   result_match_a: assert property (o_data_oe |-> o_data == o_dac_code)
      else $error("data differs from register");
   result_hold_a: assert property (o_data_oe && $past(o_data_oe) |-> $stable(o_data))
      else $error("result moved");
   done_hold_a: assert property ($rose(i_blank_convert_n) && !o_conversion_done_n
      |-> ##15 !o_conversion_done_n) else $error("done released early");
   line_release_a: assert property ($rose(i_blank_convert_n) && !o_conversion_done_n
      |-> ##16 o_conversion_done_n && !o_data_oe) else $error("no release");
   halt_quiet_a: assert property (i_blank_convert_n && o_conversion_done_n
      |=> o_conversion_done_n) else $error("done moved while blank");
   offset_steady_a: assert property (!i_blank_convert_n && !$past(i_blank_convert_n)
      |-> $stable(o_bipolar_offset_on)) else $error("offset moved in conversion");
   cover property ($fell(o_conversion_done_n));
   cover property ($rose(o_data_oe) && o_bipolar_offset_on);
   cover property (i_blank_convert_n && o_conversion_done_n && o_dac_code != 8'h00);
endmodule // sacc_conversion_control_props
bind sacc_conversion_control sacc_conversion_control_props u_props (.i_clk(i_clk),
   .i_reset_n(i_reset_n), .i_blank_convert_n(i_blank_convert_n),
   .o_conversion_done_n(o_conversion_done_n), .o_data(o_data), .o_data_oe(o_data_oe),
   .o_bipolar_offset_on(o_bipolar_offset_on), .o_dac_code(o_dac_code));

// [tb/sacc_conversion_control_tb.sv]
/* Self-checking bench for the conversion control with a comparator model.
   Assumes the design package is compiled first. */
module sacc_conversion_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sacc_pkg::*;
   logic clk = 0, rst_n = 0, bc_n = 1, bip = 0;
   logic [7:0] level = 8'h00;
   logic [7:0] lv [4] = '{8'h00, 8'h80, 8'hff, 8'h5a};
   wire logic below, done_n, oe, ofs;
   wire logic [7:0] data, dac;
   int mismatches = 0, n_tests = 0;
   sacc_conversion_control u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_blank_convert_n(bc_n),
      .i_sum_below(below), .i_bipolar_open(bip), .o_conversion_done_n(done_n),
      .o_data(data), .o_data_oe(oe), .o_bipolar_offset_on(ofs), .o_dac_code(dac));
   sacc_comparator_model u_cmp (.i_dac_code(dac), .i_level(level), .o_sum_below(below));
   initial forever #50 clk = ~clk;
   task tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bounded wait so a stuck flag shows as a mismatch, not a hang
   task await(input bit sel, input logic v);
      int k;
      k = 0;
      while ((sel ? oe : done_n) !== v && k < 40) begin
         tick(1);
         k++;
      end
      check(8'(sel ? oe : done_n), 8'(v));
   endtask
   task finish_result(input logic [7:0] exp);
      await(0, 1'b0);
      await(1, 1'b1);
      check(data, exp);
      check(8'(ofs), 8'(bip));
      bc_n = 1;
      await(0, 1'b1);
      check(8'(oe), 8'h00);
      tick(20);
   endtask
   task t_convert(input logic [7:0] l, input logic b);
      int k;
      level = l;
      bip = b;
      tick(3);
      bc_n = 0;
      k = 0;
      while (dac === 8'h00 && k < 20) begin
         tick(1);
         k++;
      end
      check(dac, 8'h80);
      finish_result(l);
      $display("convert %h bipolar %0d ended", l, b);
   endtask
   task t_halt(input int hi, input logic [7:0] exp);
      level = 8'h5a;
      bc_n = 0;
      tick(4);
      bc_n = 1;
      // New level while halted tells a resumed conversion from a fresh one
      level = 8'hc3;
      tick(hi);
      check(8'(done_n), 8'h01);
      check(8'(oe), 8'h00);
      bc_n = 0;
      finish_result(exp);
      $display("halt %0d cycles ended", hi);
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #(3000 * 100);
      mismatches++;
      stop_test;
   end
   initial begin
      tick(12);
      rst_n = 1;
      check(8'(done_n), 8'h01);
      check(8'(oe), 8'h00);
      for (int b = 0; b < 2; b++) foreach (lv[i]) t_convert(lv[i], b[0]);
      t_halt(5, 8'h5f);
      t_halt(25, 8'hc3);
      stop_test;
   end
endmodule // sacc_conversion_control_tb
